// ### verilog/fpdual_pkg.sv
// Package for the floating-point pipeline and dual-issue control block.
// Assumes one clock domain; the arithmetic itself sits outside the block.
`default_nettype none
package fpdual_pkg;

  // ----------------------------------------------------------------
  // Depths and reset values
  // ----------------------------------------------------------------
  localparam int          ADD_DEPTH     = 3;
  localparam int          MUL_DEPTH_SGL = 3;
  localparam int          MUL_DEPTH_DBL = 2;
  localparam logic [63:0] DATA_RST      = 64'h0;
  localparam logic [31:0] WORD_RST      = 32'h0;

  // ----------------------------------------------------------------
  // Operand route selects
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_SRC  = 2'h0;  // Plain source operand
  localparam logic [1:0] SEL_ALT  = 2'h1;  // Real constant / transfer / mul last stage
  localparam logic [1:0] SEL_ALT2 = 2'h2;  // Imag constant / add last stage

  typedef enum logic [1:0] {UNIT_ADD, UNIT_MUL, UNIT_DUAL} unit_t;
  typedef enum {ISS_SINGLE, ISS_ENTER, ISS_DUAL, ISS_LEAVE} issue_state_t;

  typedef struct packed {
    logic        defined;
    logic        dbl;
    logic [63:0] data;
  } stage_t;

  typedef struct packed {
    logic        valid;
    logic        dbl;
    logic        exc_en;
    logic [63:0] data;
  } wb_t;

  typedef struct packed {
    logic        valid;
    unit_t       unit;
    logic        pipelined;
    logic        src_dbl;
    logic        res_dbl;
    logic        dest_is_first_source_operand;
    logic        dest_is_second_source_operand;
    logic [3:0]  path_select_field;
    logic [63:0] first_source_operand;
    logic [63:0] second_source_operand;
  } fp_op_t;

  typedef struct packed {
    logic [1:0] m1;
    logic       m2;
    logic [1:0] a1;
    logic [1:0] a2;
    logic       ld_real;
    logic       ld_imag;
    logic       ld_xfer;
  } path_t;

  // Fixed decode of the four-bit path field
  function automatic path_t path_decode(input logic [3:0] code);
    path_t p;
    p = '{SEL_SRC, 1'b0, SEL_SRC, SEL_SRC, 1'b0, 1'b0, 1'b0};
    case (code)
      4'h0: p = '{SEL_ALT,  1'b0, SEL_SRC,  SEL_ALT,  1'b0, 1'b0, 1'b0};
      4'h1: p = '{SEL_ALT,  1'b0, SEL_ALT,  SEL_ALT,  1'b0, 1'b0, 1'b1};
      4'h2: p = '{SEL_ALT,  1'b1, SEL_SRC,  SEL_ALT,  1'b0, 1'b0, 1'b0};
      4'h3: p = '{SEL_ALT,  1'b1, SEL_ALT,  SEL_ALT,  1'b0, 1'b0, 1'b1};
      4'h4: p = '{SEL_SRC,  1'b0, SEL_ALT,  SEL_SRC,  1'b1, 1'b0, 1'b1};
      4'h5: p = '{SEL_SRC,  1'b0, SEL_ALT,  SEL_ALT2, 1'b0, 1'b1, 1'b1};
      4'h6: p = '{SEL_SRC,  1'b1, SEL_ALT2, SEL_SRC,  1'b1, 1'b0, 1'b0};
      4'h7: p = '{SEL_SRC,  1'b1, SEL_ALT2, SEL_ALT,  1'b0, 1'b1, 1'b0};
      4'h8: p = '{SEL_ALT2, 1'b0, SEL_SRC,  SEL_ALT,  1'b0, 1'b0, 1'b0};
      4'h9: p = '{SEL_ALT2, 1'b0, SEL_ALT,  SEL_ALT,  1'b0, 1'b0, 1'b1};
      4'hA: p = '{SEL_ALT2, 1'b1, SEL_SRC,  SEL_ALT,  1'b0, 1'b0, 1'b0};
      4'hB: p = '{SEL_ALT2, 1'b1, SEL_ALT,  SEL_ALT,  1'b0, 1'b0, 1'b1};
      4'hC: p = '{SEL_SRC,  1'b0, SEL_SRC,  SEL_ALT2, 1'b1, 1'b0, 1'b0};
      4'hD: p = '{SEL_SRC,  1'b0, SEL_ALT,  SEL_ALT2, 1'b0, 1'b1, 1'b1};
      4'hE: p = '{SEL_SRC,  1'b1, SEL_SRC,  SEL_SRC,  1'b0, 1'b0, 1'b1};
      4'hF: p = '{SEL_ALT,  1'b0, SEL_ALT2, SEL_ALT2, 1'b0, 1'b0, 1'b0};
      default: p = '{SEL_SRC, 1'b0, SEL_SRC, SEL_SRC, 1'b0, 1'b0, 1'b0};
    endcase
    return p;
  endfunction

endpackage
`default_nettype wire

// ### verilog/fp_pipe_ctrl.sv
// Floating-point adder/multiplier pipeline control with dual-instruction issue.
// Assumes the arithmetic units are combinational from the operand outputs,
// and that fetch supplies aligned 64-bit words with decoded flags.
`timescale 1ns/1ns
`default_nettype none
module fp_pipe_ctrl
  import fpdual_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire fp_op_t      OP,
  input  wire logic [63:0] ADD_RESULT,
  input  wire logic [63:0] MUL_RESULT,
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR_LO,
  input  wire logic [31:0] INSTR_HI,
  input  wire logic        LO_IS_FP,
  input  wire logic        DUAL_BIT,
  output logic      [63:0] ADD_OP1,
  output logic      [63:0] ADD_OP2,
  output logic      [63:0] MUL_OP1,
  output logic      [63:0] MUL_OP2,
  output wb_t              ADD_WB,
  output wb_t              MUL_WB,
  output logic             WIDE_FETCH,
  output logic             FP_ISSUE,
  output logic      [31:0] FP_WORD,
  output logic             CORE_ISSUE,
  output logic      [31:0] CORE_WORD
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    stage_t [2:0] add;
    stage_t [2:0] mul;
    logic  [63:0] kreal;
    logic  [63:0] kimag;
    logic  [63:0] xfer;
    wb_t          add_wb;
    wb_t          mul_wb;
    issue_state_t iss;
    logic         fp_iss;
    logic  [31:0] fp_word;
    logic         core_iss;
    logic  [31:0] core_word;
  } state_t;

  localparam stage_t STAGE_RST = '{1'b0, 1'b0, DATA_RST};
  localparam wb_t    WB_RST    = '{1'b0, 1'b0, 1'b0, DATA_RST};

  state_t q_r;
  state_t q_nxt;
  path_t  path;
  logic   add_go;
  logic   mul_go;
  logic   is_dual;
  logic   [1:0] mul_last;
  logic   [63:0] add_tail;
  logic   [63:0] mul_tail;
  logic   [63:0] first_source_operand_eff;
  logic   [63:0] second_source_operand_eff;

  // ----------------------------------------------------------------
  // Operand routing
  // ----------------------------------------------------------------
  // Last stage of the multiplier follows the incoming precision
  assign mul_last = OP.src_dbl ? 2'(MUL_DEPTH_DBL - 1) : 2'(MUL_DEPTH_SGL - 1);
  assign add_tail = q_r.add[ADD_DEPTH-1].data;
  assign mul_tail = q_r.mul[mul_last].data;
  assign is_dual  = OP.unit == UNIT_DUAL;
  assign add_go   = OP.valid && (OP.unit == UNIT_ADD || is_dual);
  assign mul_go   = OP.valid && (OP.unit == UNIT_MUL || is_dual);
  assign path     = path_decode(OP.path_select_field);

  // Value leaving the unit this step replaces a matching source
  always_comb begin
    first_source_operand_eff = OP.first_source_operand;
    second_source_operand_eff = OP.second_source_operand;
    if (OP.pipelined && OP.dest_is_first_source_operand) begin
      first_source_operand_eff = (OP.unit == UNIT_MUL) ? mul_tail : add_tail;
    end
    if (OP.pipelined && OP.dest_is_second_source_operand) begin
      second_source_operand_eff = (OP.unit == UNIT_MUL) ? mul_tail : add_tail;
    end
  end

  // Plain add/mul always use sources; dual ops follow the path table
  always_comb begin
    MUL_OP1 = first_source_operand_eff;
    MUL_OP2 = second_source_operand_eff;
    ADD_OP1 = first_source_operand_eff;
    ADD_OP2 = second_source_operand_eff;
    if (is_dual) begin
      case (path.m1)
        SEL_ALT:  MUL_OP1 = q_r.kreal;
        SEL_ALT2: MUL_OP1 = q_r.kimag;
        default:  MUL_OP1 = first_source_operand_eff;
      endcase
      MUL_OP2 = path.m2 ? add_tail : second_source_operand_eff;
      case (path.a1)
        SEL_ALT:  ADD_OP1 = q_r.xfer;
        SEL_ALT2: ADD_OP1 = add_tail;
        default:  ADD_OP1 = first_source_operand_eff;
      endcase
      case (path.a2)
        SEL_ALT:  ADD_OP2 = mul_tail;
        SEL_ALT2: ADD_OP2 = add_tail;
        default:  ADD_OP2 = second_source_operand_eff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.add_wb.valid = 1'b0;
    q_nxt.mul_wb.valid = 1'b0;
    q_nxt.fp_iss = 1'b0;
    q_nxt.core_iss = 1'b0;
    // Adder: pipelined step drains tail, shifts, loads head
    if (add_go && OP.pipelined) begin
      // Drained value keeps the precision and trap enable of its launch
      q_nxt.add_wb = '{1'b1, q_r.add[2].dbl, q_r.add[2].defined, add_tail};
      q_nxt.add[2] = q_r.add[1];
      q_nxt.add[1] = q_r.add[0];
      q_nxt.add[0] = '{1'b1, OP.res_dbl, ADD_RESULT};
    end else if (add_go) begin
      // Scalar runs through every stage; older contents are lost
      q_nxt.add_wb = '{1'b1, OP.res_dbl, 1'b1, ADD_RESULT};
      q_nxt.add[2] = '{1'b1, OP.res_dbl, ADD_RESULT};
      q_nxt.add[1] = STAGE_RST;
      q_nxt.add[0] = STAGE_RST;
    end
    // Multiplier: tail position depends on source precision
    if (mul_go && OP.pipelined) begin
      q_nxt.mul_wb = '{1'b1, q_r.mul[mul_last].dbl, q_r.mul[mul_last].defined,
                       mul_tail};
      q_nxt.mul[2] = q_r.mul[1];
      q_nxt.mul[1] = q_r.mul[0];
      q_nxt.mul[0] = '{1'b1, OP.res_dbl, MUL_RESULT};
    end else if (mul_go) begin
      q_nxt.mul_wb = '{1'b1, OP.res_dbl, 1'b1, MUL_RESULT};
      q_nxt.mul = {3{STAGE_RST}};
      q_nxt.mul[mul_last] = '{1'b1, OP.res_dbl, MUL_RESULT};
    end
    // Special registers of the dual-operation paths
    if (is_dual && OP.valid) begin
      if (path.ld_real) begin
        q_nxt.kreal = OP.first_source_operand;
      end
      if (path.ld_imag) begin
        q_nxt.kimag = OP.first_source_operand;
      end
      if (path.ld_xfer) begin
        q_nxt.xfer = mul_tail;
      end
    end
    // Issue sequencing between single and paired words
    if (INSTR_VALID) begin
      case (q_r.iss)
        ISS_SINGLE: begin
          q_nxt.fp_iss = LO_IS_FP;
          q_nxt.core_iss = !LO_IS_FP;
          q_nxt.fp_word = INSTR_LO;
          q_nxt.core_word = INSTR_LO;
          if (LO_IS_FP && DUAL_BIT) begin
            q_nxt.iss = ISS_ENTER;
          end
        end
        ISS_ENTER: begin
          // Exactly one more 32-bit word before pairing starts
          q_nxt.fp_iss = LO_IS_FP;
          q_nxt.core_iss = !LO_IS_FP;
          q_nxt.fp_word = INSTR_LO;
          q_nxt.core_word = INSTR_LO;
          q_nxt.iss = ISS_DUAL;
        end
        ISS_DUAL, ISS_LEAVE: begin
          // Both halves always go, even right after a delayed branch
          q_nxt.fp_iss = 1'b1;
          q_nxt.core_iss = 1'b1;
          q_nxt.fp_word = INSTR_LO;
          q_nxt.core_word = INSTR_HI;
          if (q_r.iss == ISS_LEAVE) begin
            q_nxt.iss = ISS_SINGLE;
          end else if (!DUAL_BIT) begin
            q_nxt.iss = ISS_LEAVE;
          end
        end
        default: q_nxt.iss = ISS_SINGLE;
      endcase
    end
  end

  // Single register stage for all control state
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      q_r <= '{{3{STAGE_RST}}, {3{STAGE_RST}}, DATA_RST, DATA_RST, DATA_RST,
               WB_RST, WB_RST, ISS_SINGLE, 1'b0, WORD_RST, 1'b0, WORD_RST};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ADD_WB     = q_r.add_wb;
  assign MUL_WB     = q_r.mul_wb;
  assign WIDE_FETCH = (q_r.iss == ISS_DUAL) || (q_r.iss == ISS_LEAVE);
  assign FP_ISSUE   = q_r.fp_iss;
  assign FP_WORD    = q_r.fp_word;
  assign CORE_ISSUE = q_r.core_iss;
  assign CORE_WORD  = q_r.core_word;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic pa;
  logic pm;
  assign pa = add_go && OP.pipelined;
  assign pm = mul_go && OP.pipelined;

  a_add_drain: assert property (pa |=> ADD_WB.valid &&
                                ADD_WB.data == $past(q_r.add[2].data))
    else $error("adder did not drain its third stage");
  a_add_shift: assert property (pa |=> q_r.add[2] == $past(q_r.add[1]))
    else $error("adder stages did not advance");
  a_new_prec: assert property (pa |=> q_r.add[0].dbl == $past(OP.res_dbl))
    else $error("head stage precision wrong");
  a_drain_prec: assert property (pa |=> ADD_WB.dbl == $past(q_r.add[2].dbl))
    else $error("drained precision not the launching one");
  a_mul_dbl: assert property (pm && OP.src_dbl |=>
                              MUL_WB.data == $past(q_r.mul[1].data))
    else $error("double multiply depth not two");
  a_mul_sgl: assert property (pm && !OP.src_dbl |=>
                              MUL_WB.data == $past(q_r.mul[2].data))
    else $error("single multiply depth not three");
  a_scalar_flush: assert property (add_go && !OP.pipelined |=>
                                   !q_r.add[0].defined && !q_r.add[1].defined)
    else $error("scalar left stages defined");
  // Head stage of the multiplier is never its tail, so a scalar leaves it undefined
  a_mul_flush: assert property (mul_go && !OP.pipelined |=>
                                !q_r.mul[0].defined && MUL_WB.data == $past(MUL_RESULT))
    else $error("scalar multiply did not flush its unit");
  a_undef_notrap: assert property (pa && !q_r.add[2].defined |=> !ADD_WB.exc_en)
    else $error("undefined result may trap");
  a_fwd_first_source_operand: assert property (OP.pipelined && OP.dest_is_first_source_operand &&
                               OP.unit == UNIT_ADD |-> ADD_OP1 == add_tail)
    else $error("forwarded operand wrong");
  a_xfer_load: assert property (is_dual && OP.valid && path.ld_xfer |=>
                                q_r.xfer == $past(mul_tail))
    else $error("transfer register not loaded");
  a_real_load: assert property (is_dual && OP.valid && path.ld_real |=>
                                q_r.kreal == $past(OP.first_source_operand))
    else $error("real constant register not loaded");
  a_dual_both: assert property (is_dual && OP.valid |=>
                                ADD_WB.valid && MUL_WB.valid)
    else $error("dual operation did not advance both units");
  a_enter_dual: assert property (q_r.iss == ISS_SINGLE && INSTR_VALID &&
                                 LO_IS_FP && DUAL_BIT ##1 INSTR_VALID |=> WIDE_FETCH)
    else $error("pairing did not start after one word");
  a_leave_dual: assert property (q_r.iss == ISS_LEAVE && INSTR_VALID |=>
                                 !WIDE_FETCH && CORE_ISSUE && FP_ISSUE)
    else $error("single issue not resumed after one pair");

  c_dual_op: cover property (is_dual && OP.valid && path.ld_real);
  c_pair_run: cover property (q_r.iss == ISS_DUAL && INSTR_VALID ##1 q_r.iss == ISS_LEAVE);
  c_scalar_mul: cover property (mul_go && !OP.pipelined ##1 pm);
  c_fwd_add: cover property (pa && OP.dest_is_first_source_operand);

endmodule
`default_nettype wire

// ### verif/fp_arith_model.sv
// Stand-in for the adder and multiplier arithmetic beside the control block.
// Assumes operands come combinationally and results are wanted in that cycle.
`timescale 1ns/1ns
`default_nettype none
module fp_arith_model (
  input  wire logic [63:0] add_op1,
  input  wire logic [63:0] add_op2,
  input  wire logic [63:0] mul_op1,
  input  wire logic [63:0] mul_op2,
  output logic      [63:0] add_result,
  output logic      [63:0] mul_result
);
  // ----------------------------------------------------------------
  // Integer stand-ins
  // ----------------------------------------------------------------
  // Plain integers keep every expected value easy to reckon by hand
  assign add_result = add_op1 + add_op2;
  assign mul_result = mul_op1 * mul_op2;  // Low half only; operands stay small
endmodule
`default_nettype wire

// ### verif/fp_pipeline_dual_issue_control_test.sv
// Self-checking bench for the pipeline and dual-issue control block.
// Assumes the arithmetic stand-in model; outputs are sampled at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module fp_pipeline_dual_issue_control_test;
  import fpdual_pkg::*;
  localparam fp_op_t IDLE = '0;
  logic        core_clk, rst, instr_valid, lo_is_fp, dual_bit;
  logic        wide_fetch, fp_issue, core_issue, c_fi, c_ci, c_wf;
  logic [31:0] instr_lo, instr_hi, fp_word, core_word, c_fw, c_cw;
  logic [63:0] add_result, mul_result, add_op1, add_op2, mul_op1, mul_op2;
  logic [63:0] c_a1, c_a2, c_m1, c_m2;
  fp_op_t      op;
  wb_t         add_wb, mul_wb, c_aw, c_mw;
  int          bad_count, samples_checked;

  fp_pipe_ctrl u_dut (.CORE_CLK(core_clk), .RST(rst), .OP(op), .ADD_RESULT(add_result),
    .MUL_RESULT(mul_result), .INSTR_VALID(instr_valid), .INSTR_LO(instr_lo),
    .INSTR_HI(instr_hi), .LO_IS_FP(lo_is_fp), .DUAL_BIT(dual_bit), .ADD_OP1(add_op1),
    .ADD_OP2(add_op2), .MUL_OP1(mul_op1), .MUL_OP2(mul_op2), .ADD_WB(add_wb),
    .MUL_WB(mul_wb), .WIDE_FETCH(wide_fetch), .FP_ISSUE(fp_issue), .FP_WORD(fp_word),
    .CORE_ISSUE(core_issue), .CORE_WORD(core_word));
  fp_arith_model u_arith (.add_op1(add_op1), .add_op2(add_op2), .mul_op1(mul_op1),
    .mul_op2(mul_op2), .add_result(add_result), .mul_result(mul_result));

  // ----------------------------------------------------------------
  // Clock, access tasks and comparison
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Flags nibble: pipelined, source double, result double, dest equals first_source_operand
  function automatic fp_op_t mk(unit_t u, logic [3:0] f, logic [3:0] pf,
                                logic [63:0] a, logic [63:0] b);
    mk = '{1'b1, u, f[3], f[2], f[1], f[0], 1'b0, pf, a, b};
  endfunction

  // Falling-edge snapshot: registered outputs show the previous request
  task automatic grab;
    @(negedge core_clk);
    c_aw = add_wb;
    c_mw = mul_wb;
    c_a1 = add_op1;
    c_a2 = add_op2;
    c_m1 = mul_op1;
    c_m2 = mul_op2;
    c_fi = fp_issue;
    c_ci = core_issue;
    c_fw = fp_word;
    c_cw = core_word;
    c_wf = wide_fetch;
    @(posedge core_clk);
  endtask

  task automatic step(input fp_op_t o);
    op <= o;
    grab();
  endtask

  task automatic fetch(input logic v, input logic fp, input logic d,
                       input logic [31:0] lo, input logic [31:0] hi);
    instr_valid <= v;
    lo_is_fp    <= fp;
    dual_bit    <= d;
    instr_lo    <= lo;
    instr_hi    <= hi;
    grab();
  endtask

  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about forty cycles
  initial begin
    repeat (400) @(posedge core_clk);
    bad_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    samples_checked = 0;
    op = IDLE;
    {instr_valid, lo_is_fp, dual_bit, instr_lo, instr_hi} = '0;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // Adder: a later op with other precision drains the first result
    step(mk(UNIT_ADD, 4'hE, 4'h0, 64'h1, 64'h2));
    step(mk(UNIT_ADD, 4'hC, 4'h0, 64'h3, 64'h4));
    step(mk(UNIT_ADD, 4'hE, 4'h0, 64'h5, 64'h6));
    step(mk(UNIT_ADD, 4'h8, 4'h0, 64'h7, 64'h8));
    step(IDLE);
    check("add_wb_valid", c_aw.valid, 64'h1);
    check("add_wb_data", c_aw.data, 64'h3);
    check("add_wb_dbl", c_aw.dbl, 64'h1);
    // Multiplier: three singles deep, then doubles two deep
    step(mk(UNIT_MUL, 4'h8, 4'h0, 64'h2, 64'h3));
    check("add_wb_pulse", c_aw.valid, 64'h0);
    step(mk(UNIT_MUL, 4'h8, 4'h0, 64'h4, 64'h5));
    step(mk(UNIT_MUL, 4'h8, 4'h0, 64'h6, 64'h7));
    step(mk(UNIT_MUL, 4'h8, 4'h0, 64'h8, 64'h9));
    step(mk(UNIT_MUL, 4'hE, 4'h0, 64'hA, 64'hB));
    check("mul_wb_single", c_mw.data, 64'h6);
    step(mk(UNIT_MUL, 4'hE, 4'h0, 64'hC, 64'hD));
    check("mul_wb_double", c_mw.data, 64'h2A);
    check("mul_wb_dbl", c_mw.dbl, 64'h0);
    step(IDLE);
    check("mul_wb_double2", c_mw.data, 64'h48);
    // Scalar add discards pending adds; drained flushed stages carry no trap enable
    step(mk(UNIT_ADD, 4'h6, 4'h0, 64'hA, 64'h14));
    step(mk(UNIT_ADD, 4'hE, 4'h0, 64'h1, 64'h1));
    check("scalar_data", c_aw.data, 64'h1E);
    check("scalar_exc", c_aw.exc_en, 64'h1);
    step(mk(UNIT_ADD, 4'hE, 4'h0, 64'h2, 64'h2));
    step(mk(UNIT_ADD, 4'hE, 4'h0, 64'h3, 64'h3));
    check("undef_exc1", c_aw.exc_en, 64'h0);
    step(IDLE);
    check("undef_exc2", c_aw.exc_en, 64'h0);
    // Destination equals first source, precisions kept equal
    step(mk(UNIT_ADD, 4'hF, 4'h0, 64'hFF, 64'h5));
    check("forward_op1", c_a1, 64'h2);
    // Dual operations: constant and transfer registers through the path field
    step(mk(UNIT_DUAL, 4'hE, 4'h4, 64'h100, 64'h3));
    step(mk(UNIT_DUAL, 4'hE, 4'h0, 64'h7, 64'h9));
    check("dual_add_wb", c_aw.valid, 64'h1);
    check("dual_mul_wb", c_mw.valid, 64'h1);
    check("mul_op1_real", c_m1, 64'h100);
    check("add_op1_src", c_a1, 64'h7);
    step(mk(UNIT_DUAL, 4'hE, 4'h1, 64'h8, 64'h2));
    check("add_op1_xfer", c_a1, 64'h6E);
    step(mk(UNIT_DUAL, 4'hE, 4'h5, 64'h200, 64'h1));
    check("add_op2_tail", c_a2, 64'h3);
    check("mul_op1_src", c_m1, 64'h200);
    step(mk(UNIT_DUAL, 4'hE, 4'h8, 64'h1, 64'h1));
    check("mul_op1_imag", c_m1, 64'h200);
    step(mk(UNIT_DUAL, 4'hE, 4'h2, 64'h1, 64'h5));
    check("mul_op2_add", c_m2, 64'h36E);
    // Dummy multiplies empty the unit first; later drains target a zero destination
    step(mk(UNIT_MUL, 4'hE, 4'h0, 64'h0, 64'h0));
    step(mk(UNIT_MUL, 4'hE, 4'h0, 64'h0, 64'h0));
    step(mk(UNIT_MUL, 4'h6, 4'h0, 64'h3, 64'h5));
    step(mk(UNIT_MUL, 4'hE, 4'h0, 64'h2, 64'h2));
    check("scalar_mul", c_mw.data, 64'hF);
    check("scalar_mul_exc", c_mw.exc_en, 64'h1);
    step(mk(UNIT_MUL, 4'hE, 4'h0, 64'h2, 64'h2));
    step(IDLE);
    check("mul_undef_exc", c_mw.exc_en, 64'h0);
    // Issue: enter dual after one more word, leave after one more pair
    fetch(1'b1, 1'b1, 1'b1, 32'h11, 32'h91);
    fetch(1'b1, 1'b0, 1'b0, 32'h22, 32'h92);
    check("enter_fp", {c_fi, c_ci, c_wf, c_fw}, {3'h4, 32'h11});
    fetch(1'b1, 1'b1, 1'b1, 32'h33, 32'h44);
    check("enter_core", {c_fi, c_ci, c_wf, c_cw}, {3'h3, 32'h22});
    fetch(1'b1, 1'b1, 1'b0, 32'h55, 32'h66);
    check("pair", {c_fi, c_ci, c_fw, c_cw}, {2'h3, 32'h33, 32'h44});
    fetch(1'b1, 1'b1, 1'b0, 32'h77, 32'h88);
    check("leave", {c_fi, c_ci, c_wf, c_fw, c_cw}, {3'h7, 32'h55, 32'h66});
    fetch(1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
    check("last", {c_fi, c_ci, c_wf, c_fw, c_cw}, {3'h6, 32'h77, 32'h88});
    results();
  end
endmodule
`default_nettype wire
